// >>> design/ifp_pkg.sv
package ifp_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int IW = 16;
  localparam int DA_W = 12;
  localparam int DW = 8;
  localparam int TP_W = 22;
  localparam int SP_W = 5;
  localparam int FSR_N = 3;

  // ---------------------------------------------------------------
  // Reset values, steps and address map
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [3:0] PH_OH_RESET = 4'h1;
  localparam logic [3:0] TWO_WORD_TAG = 4'hf;
  localparam logic [DA_W-1:0] SFR_BASE = 12'hf80;
  localparam logic [DW-1:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [DA_W-1:0] ADR_BANK_SELECT_REGISTER = 12'hfe0;
  localparam logic [DA_W-1:0] ADR_WORKING_REGISTER = 12'hfe8;
  localparam logic [DA_W-1:0] ADR_TABLE_LATCH = 12'hff5;
  localparam logic [DA_W-1:0] ADR_TBL_L = 12'hff6;
  localparam logic [DA_W-1:0] ADR_TBL_H = 12'hff7;
  localparam logic [DA_W-1:0] ADR_TBL_U = 12'hff8;
  localparam logic [DA_W-1:0] ADR_PC_LOW_BYTE = 12'hff9;
  localparam logic [DA_W-1:0] ADR_STACK_POINTER = 12'hffc;

  // ---------------------------------------------------------------
  // Opcode patterns, compared against the top bits of a word
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_LIT_TO_W = 8'h0e;
  localparam logic [7:0] OPC_RET_LIT = 8'h0c;
  localparam logic [14:0] OPC_RETURN = 15'h0009;
  localparam logic [15:0] OPC_TABLE_READ = 16'h0008;
  localparam logic [7:0] OPC_ABS_JUMP = 8'hef;
  localparam logic [6:0] OPC_ABS_CALL = 7'h76;
  localparam logic [9:0] OPC_PTR_LOAD = 10'h3b8;
  localparam logic [3:0] OPC_MEM_MOVE = 4'hc;
  localparam logic [4:0] OPC_REL_BRANCH = 5'h1a;
  localparam logic [5:0] OPC_ADD_W_FILE = 6'h09;
  localparam logic [5:0] OPC_FILE_TO_W = 6'h14;
  localparam logic [6:0] OPC_W_TO_FILE = 7'h37;
  localparam logic [6:0] OPC_TEST_SKIP = 7'h33;

  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR = 2'b10
  } ifp_phase_e;

  typedef enum logic [3:0] {
    OP_NOP, OP_LIT_TO_W, OP_ABS_JUMP, OP_ABS_CALL, OP_MEM_MOVE, OP_PTR_LOAD, OP_REL_BRANCH,
    OP_RET_LIT, OP_RETURN, OP_TABLE_READ, OP_ADD_W_FILE, OP_FILE_TO_W, OP_W_TO_FILE, OP_TEST_SKIP
  } ifp_op_e;

  function automatic logic [3:0] ifp_phase_onehot(input ifp_phase_e ph);
    logic [3:0] oh;
    unique case (ph)
      PH_ONE: oh = 4'h1;
      PH_TWO: oh = 4'h2;
      PH_THREE: oh = 4'h4;
      PH_FOUR: oh = 4'h8;
    endcase
    return oh;
  endfunction : ifp_phase_onehot

endpackage : ifp_pkg

// >>> design/ifp_phase.sv
module ifp_phase import ifp_pkg::*; (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  output ifp_phase_e phase, // Current quadrature phase
  output logic [3:0] phase_oh // Same phase, one-hot
);

  typedef struct packed {
    ifp_phase_e ph;
    logic [3:0] oh;
  } ifp_phase_s;

  ifp_phase_s s_q;
  ifp_phase_s s_d;

  // ---------------------------------------------------------------
  // Divide by four
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    unique case (s_q.ph)
      PH_ONE: s_d.ph = PH_TWO;
      PH_TWO: s_d.ph = PH_THREE;
      PH_THREE: s_d.ph = PH_FOUR;
      PH_FOUR: s_d.ph = PH_ONE;
    endcase
    s_d.oh = ifp_phase_onehot(s_d.ph);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.ph <= PH_ONE;
      s_q.oh <= PH_OH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.ph;
  assign phase_oh = s_q.oh;

  a_phase_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.ph == PH_ONE |=> s_q.ph == PH_TWO ##1 s_q.ph == PH_THREE ##1 s_q.ph == PH_FOUR ##1 s_q.ph == PH_ONE)
    else $error("phase sequence broken");
  a_phase_single: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(s_q.oh) && s_q.oh == ifp_phase_onehot(s_q.ph))
    else $error("phase outputs overlap or disagree");

endmodule : ifp_phase

// >>> design/ifp_mem.sv
module ifp_mem import ifp_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [ADDR_W-1:0] wr_addr, // Write address
  input wire logic [DATA_W-1:0] wr_data, // Write data
  input wire logic rd_en, // Read strobe
  input wire logic [ADDR_W-1:0] rd_addr, // Read address
  output logic [DATA_W-1:0] rd_data // Registered read data
);

  if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin : g_bad_size
    $error("ifp_mem: unsupported size");
  end

  typedef struct packed {
    logic [(1<<ADDR_W)-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rd;
  } ifp_mem_s;

  ifp_mem_s s_q;
  ifp_mem_s s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      s_d.rd = s_q.mem[rd_addr];
    end
  end

  // Contents survive reset, as plain RAM would
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.mem <= s_d.mem;
      s_q.rd <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd;

endmodule : ifp_mem

// >>> design/ifp_core.sv
module ifp_core import ifp_pkg::*; (
  input wire logic CLK, // Core clock, 125 MHz
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic [IW-1:0] PM_RDATA, // Program word at PM_ADDR with bit 0 dropped
  output logic [PC_W-1:0] PM_ADDR, // Program memory byte address
  output logic [3:0] PHASE, // One-hot phase, bit 0 is phase one
  output logic [PC_W-1:0] PC_OUT, // Program counter
  output logic [DW-1:0] WORKING_REGISTER_OUT, // Working register
  output logic [DW-1:0] TBL_LATCH_OUT, // Table latch
  output logic EXEC_VALID // Instruction register holds a live word
);

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] pm_addr;
    logic [PC_W-1:0] fetch_pc;
    logic [IW-1:0] fetch_w;
    logic fetch_v;
    logic [IW-1:0] ir;
    logic [PC_W-1:0] ir_pc;
    logic ir_v;
    ifp_op_e pend;
    logic [IW-1:0] first_w;
    logic [DW-1:0] hold;
    logic [DW-1:0] opd;
    logic [DW-1:0] working_register;
    logic [3:0] bank_select_register;
    logic [TP_W-1:0] table_pointer;
    logic [DW-1:0] table_latch;
    logic [SP_W-1:0] sp;
    logic [FSR_N-1:0][DA_W-1:0] fsr;
  } ifp_core_s;

  ifp_core_s s_q;
  ifp_core_s s_d;

  ifp_phase_e phase;
  logic [3:0] phase_oh;
  ifp_op_e op;
  logic second;
  logic pend_hit;
  logic file_op;
  logic sfr_hit;
  logic [DA_W-1:0] fadr;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] jump_tgt;
  logic [PC_W-1:0] branch_tgt;
  logic [DW-1:0] sfr_val;
  logic [DW-1:0] res;
  logic flush;
  logic skip;
  logic fw_en;
  logic [DA_W-1:0] fw_addr;
  logic [DW-1:0] fw_data;
  logic dm_re;
  logic dm_we;
  logic [DW-1:0] dm_rdata;
  logic stk_re;
  logic stk_we;
  logic [SP_W-1:0] stk_waddr;
  logic [PC_W-1:0] stk_rdata;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic ifp_op_e ifp_decode(input logic [IW-1:0] w);
    ifp_op_e o;
    o = OP_NOP;
    if (w[15:8] == OPC_LIT_TO_W) o = OP_LIT_TO_W;
    else if (w[15:8] == OPC_RET_LIT) o = OP_RET_LIT;
    else if (w[15:1] == OPC_RETURN) o = OP_RETURN;
    else if (w == OPC_TABLE_READ) o = OP_TABLE_READ;
    else if (w[15:8] == OPC_ABS_JUMP) o = OP_ABS_JUMP;
    else if (w[15:9] == OPC_ABS_CALL) o = OP_ABS_CALL;
    else if (w[15:6] == OPC_PTR_LOAD) o = OP_PTR_LOAD;
    else if (w[15:12] == OPC_MEM_MOVE) o = OP_MEM_MOVE;
    else if (w[15:11] == OPC_REL_BRANCH) o = OP_REL_BRANCH;
    else if (w[15:10] == OPC_ADD_W_FILE) o = OP_ADD_W_FILE;
    else if (w[15:10] == OPC_FILE_TO_W) o = OP_FILE_TO_W;
    else if (w[15:9] == OPC_W_TO_FILE) o = OP_W_TO_FILE;
    else if (w[15:9] == OPC_TEST_SKIP) o = OP_TEST_SKIP;
    return o;
  endfunction : ifp_decode

  // Fast-access space: low half of bank zero plus the top half of bank fifteen
  function automatic logic [DA_W-1:0] ifp_file_addr(input logic banked, input logic [DW-1:0] f,
                                                    input logic [3:0] bank);
    logic [DA_W-1:0] a;
    if (banked) a = {bank, f};
    else if (f < ACCESS_SPLIT) a = {ACCESS_LO_BANK, f};
    else a = {ACCESS_HI_BANK, f};
    return a;
  endfunction : ifp_file_addr

  // ---------------------------------------------------------------
  // Phase generator and memories
  // ---------------------------------------------------------------
  ifp_phase u_phase (
    .clk(CLK),
    .rst_n(RST_N),
    .phase(phase),
    .phase_oh(phase_oh)
  );

  // Full 4096-byte array; the special register half of bank fifteen is shadowed by the mux below
  ifp_mem #(.ADDR_W(DA_W), .DATA_W(DW)) u_data_mem (
    .clk(CLK),
    .rst_n(RST_N),
    .wr_en(dm_we),
    .wr_addr(fw_addr),
    .wr_data(fw_data),
    .rd_en(dm_re),
    .rd_addr(fadr),
    .rd_data(dm_rdata)
  );

  // Slot zero is written only when the 5-bit pointer wraps: the pointer is pre-incremented before a store
  ifp_mem #(.ADDR_W(SP_W), .DATA_W(PC_W)) u_stack (
    .clk(CLK),
    .rst_n(RST_N),
    .wr_en(stk_we),
    .wr_addr(stk_waddr),
    .wr_data(s_q.pc),
    .rd_en(stk_re),
    .rd_addr(s_q.sp),
    .rd_data(stk_rdata)
  );

  // ---------------------------------------------------------------
  // Pipeline
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    op = ifp_decode(s_q.ir);
    second = (s_q.ir[IW-1:IW-4] == TWO_WORD_TAG);
    pend_hit = s_q.ir_v && second && (s_q.pend != OP_NOP);
    file_op = s_q.ir_v && (op inside {OP_ADD_W_FILE, OP_FILE_TO_W, OP_W_TO_FILE, OP_TEST_SKIP, OP_MEM_MOVE});
    if (op == OP_MEM_MOVE) fadr = s_q.ir[DA_W-1:0];
    else fadr = ifp_file_addr(s_q.ir[8], s_q.ir[7:0], s_q.bank_select_register);
    next_pc = PC_W'(s_q.ir_pc + PC_STEP);
    jump_tgt = {PM_RDATA[11:0], s_q.ir[7:0], 1'b0};
    branch_tgt = PC_W'(next_pc + {{9{s_q.ir[10]}}, s_q.ir[10:0], 1'b0});
    res = DW'(s_q.opd + s_q.working_register);
    flush = 1'b0;
    skip = 1'b0;
    fw_en = 1'b0;
    fw_addr = fadr;
    fw_data = s_q.opd;
    stk_we = 1'b0;
    stk_waddr = SP_W'(s_q.sp + 1'b1);
    sfr_hit = 1'b1;
    unique case (fadr)
      ADR_WORKING_REGISTER: sfr_val = s_q.working_register;
      ADR_BANK_SELECT_REGISTER: sfr_val = DW'(s_q.bank_select_register);
      ADR_PC_LOW_BYTE: sfr_val = next_pc[7:0];
      ADR_TBL_U: sfr_val = DW'(s_q.table_pointer[TP_W-1:16]);
      ADR_TBL_H: sfr_val = s_q.table_pointer[15:8];
      ADR_TBL_L: sfr_val = s_q.table_pointer[7:0];
      ADR_TABLE_LATCH: sfr_val = s_q.table_latch;
      ADR_STACK_POINTER: sfr_val = DW'(s_q.sp);
      default: begin
        sfr_val = '0;
        sfr_hit = 1'b0;
      end
    endcase
    dm_re = (phase == PH_TWO) && file_op && (fadr < SFR_BASE);
    stk_re = (phase == PH_TWO) && s_q.ir_v && (op inside {OP_RET_LIT, OP_RETURN});

    // Fetch stage and execute stage advance together once every four cycles, in phase one
    if (phase == PH_ONE) begin
      s_d.pc = PC_W'(s_q.pc + PC_STEP);
      s_d.pm_addr = s_q.pc;
      s_d.fetch_pc = s_q.pc;
      s_d.ir = s_q.fetch_w;
      s_d.ir_v = s_q.fetch_v;
      s_d.ir_pc = s_q.fetch_pc;
    end

    // Table read borrows the program port in phases two and three
    if (phase == PH_TWO && s_q.ir_v && op == OP_TABLE_READ) begin
      s_d.pm_addr = s_q.table_pointer[PC_W-1:0];
    end

    if (phase == PH_THREE) begin
      s_d.opd = (fadr >= SFR_BASE) ? sfr_val : dm_rdata;
      if (s_q.ir_v && op == OP_TABLE_READ) begin
        s_d.table_latch = s_q.table_pointer[0] ? PM_RDATA[15:8] : PM_RDATA[7:0];
        s_d.pm_addr = s_q.fetch_pc;
      end
    end

    if (phase == PH_FOUR) begin
      s_d.fetch_w = PM_RDATA;
      if (pend_hit) begin
        if (s_q.pend == OP_MEM_MOVE) begin
          fw_en = 1'b1;
          fw_addr = s_q.ir[DA_W-1:0];
          fw_data = s_q.hold;
        end else if (s_q.first_w[5:4] < 2'(FSR_N)) begin
          s_d.fsr[s_q.first_w[5:4]] = {s_q.first_w[3:0], s_q.ir[7:0]};
        end
      end else if (s_q.ir_v) begin
        unique case (op)
          OP_NOP, OP_PTR_LOAD, OP_TABLE_READ: begin
          end
          OP_LIT_TO_W: s_d.working_register = s_q.ir[7:0];
          OP_ABS_JUMP: begin
            s_d.pc = jump_tgt;
            flush = 1'b1;
          end
          OP_ABS_CALL: begin
            s_d.pc = jump_tgt;
            flush = 1'b1;
            stk_we = 1'b1;
            s_d.sp = stk_waddr;
          end
          OP_MEM_MOVE: s_d.hold = s_q.opd;
          OP_REL_BRANCH: begin
            s_d.pc = branch_tgt;
            flush = 1'b1;
          end
          OP_RET_LIT, OP_RETURN: begin
            s_d.pc = stk_rdata;
            s_d.sp = SP_W'(s_q.sp - 1'b1);
            flush = 1'b1;
            if (op == OP_RET_LIT) begin
              s_d.working_register = s_q.ir[7:0];
            end
          end
          OP_ADD_W_FILE: begin
            fw_en = s_q.ir[9];
            fw_data = res;
            if (!s_q.ir[9]) begin
              s_d.working_register = res;
            end
          end
          OP_FILE_TO_W: begin
            fw_en = s_q.ir[9];
            if (!s_q.ir[9]) begin
              s_d.working_register = s_q.opd;
            end
          end
          OP_W_TO_FILE: begin
            fw_en = 1'b1;
            fw_data = s_q.working_register;
          end
          OP_TEST_SKIP: skip = (s_q.opd == '0);
        endcase
      end

      // Register-file writes; a write to the counter low byte is a computed jump
      if (fw_en) begin
        unique case (fw_addr)
          ADR_WORKING_REGISTER: s_d.working_register = fw_data;
          ADR_BANK_SELECT_REGISTER: s_d.bank_select_register = fw_data[3:0];
          ADR_TBL_U: s_d.table_pointer[TP_W-1:16] = fw_data[TP_W-17:0];
          ADR_TBL_H: s_d.table_pointer[15:8] = fw_data;
          ADR_TBL_L: s_d.table_pointer[7:0] = fw_data;
          ADR_TABLE_LATCH: s_d.table_latch = fw_data;
          ADR_PC_LOW_BYTE: begin
            s_d.pc = {next_pc[PC_W-1:8], fw_data[7:1], 1'b0};
            flush = 1'b1;
          end
          default: begin
          end
        endcase
      end

      s_d.pend = OP_NOP;
      if (s_q.ir_v && !second && (op inside {OP_MEM_MOVE, OP_PTR_LOAD})) begin
        s_d.pend = op;
        s_d.first_w = s_q.ir;
      end
      // The word latched now is dropped on a branch or a skip
      s_d.fetch_v = !(flush || skip);
    end
    dm_we = fw_en && (fw_addr < SFR_BASE);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign PM_ADDR = s_q.pm_addr;
  assign PHASE = phase_oh;
  assign PC_OUT = s_q.pc;
  assign WORKING_REGISTER_OUT = s_q.working_register;
  assign TBL_LATCH_OUT = s_q.table_latch;
  assign EXEC_VALID = s_q.ir_v;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_pc_advance: assert property (phase == PH_ONE |=> s_q.pc == PC_W'($past(s_q.pc) + PC_STEP))
    else $error("counter did not step one word in phase one");
  a_pc_even: assert property (!s_q.pc[0])
    else $error("counter low bit set");
  a_ir_load: assert property (phase == PH_ONE |=> s_q.ir == $past(s_q.fetch_w) && s_q.ir_v == $past(s_q.fetch_v))
    else $error("instruction register not loaded from fetch latch");
  a_fetch_latch: assert property (phase == PH_FOUR |=> s_q.fetch_w == $past(PM_RDATA))
    else $error("fetch word not latched in phase four");
  a_flush_two: assert property (phase == PH_FOUR && flush |=> !s_q.fetch_v ##1 !s_q.ir_v)
    else $error("branch did not discard prefetched word");
  a_read_phase: assert property (dm_re |-> phase == PH_TWO)
    else $error("data read outside phase two");
  a_write_phase: assert property (dm_we |-> phase == PH_FOUR && fw_addr < SFR_BASE)
    else $error("data write outside phase four");
  a_jump_target: assert property (phase == PH_FOUR && s_q.ir_v && op == OP_ABS_JUMP
    |=> s_q.pc == $past(jump_tgt) ##1 s_q.pm_addr == $past(jump_tgt, 2))
    else $error("jump did not fetch from embedded word address");
  a_call_push: assert property (phase == PH_FOUR && s_q.ir_v && op == OP_ABS_CALL
    |-> stk_we && stk_waddr == SP_W'(s_q.sp + 1'b1) ##1 s_q.sp == $past(stk_waddr))
    else $error("call push order wrong");
  a_lone_second: assert property (phase == PH_FOUR && s_q.ir_v && second && s_q.pend == OP_NOP
    |-> !fw_en && !flush && !skip)
    else $error("lone second word had an effect");
  a_skip_squash: assert property (phase == PH_FOUR && s_q.ir_v && op == OP_TEST_SKIP && s_q.opd == '0
    |=> !s_q.fetch_v ##1 !s_q.ir_v && s_q.pc == PC_W'($past(s_q.pc, 2) + PC_STEP))
    else $error("skip did not squash next word");
  a_unimpl_zero: assert property (phase == PH_THREE && file_op && fadr >= SFR_BASE && !sfr_hit
    |=> s_q.opd == '0)
    else $error("unimplemented location read nonzero");
  a_reset_empty: assert property ($rose(RST_N) |-> !s_q.ir_v [*4])
    else $error("pipeline live right after reset");

  c_branch: cover property (phase == PH_FOUR && flush ##4 s_q.ir_v);
  c_skip: cover property (phase == PH_FOUR && skip);
  c_two_word: cover property (phase == PH_FOUR && pend_hit && s_q.pend == OP_MEM_MOVE);
  c_lone_second: cover property (phase == PH_FOUR && s_q.ir_v && second && s_q.pend == OP_NOP);

endmodule : ifp_core

// >>> verification/ifp_rom_model.sv
module ifp_rom_model import ifp_pkg::*; (
  input wire logic [PC_W-1:0] pm_addr, // Byte address from the core
  output logic [IW-1:0] pm_rdata // Word at the even address, no wait state
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Program image, one word per even byte address
  // ---------------------------------------------------------------
  logic [IW-1:0] rom [0:24];

  // Call at 1e lands on the literal return at 30; the move at 22 copies the table latch into W
  initial begin
    rom = '{16'h0e55, 16'hef04, 16'hf000, 16'h0e99, 16'h0e00, 16'h6e01, 16'h6601, 16'h0e77, 16'hf123,
            16'h0e03, 16'h6ef6, 16'h0008, 16'h0e02, 16'h26f9, 16'h0e66, 16'hec18, 16'hf000, 16'hcff5,
            16'hffe8, 16'hd7ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0c42};
  end

  // Unprogrammed words read as erased, which the core decodes as a no-op
  assign pm_rdata = (pm_addr[PC_W-1:1] < 20'h00019) ? rom[pm_addr[5:1]] : 16'hffff;
endmodule : ifp_rom_model

// >>> verification/testbench.sv
module testbench import ifp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [IW-1:0] pm_rdata;
  logic [PC_W-1:0] pm_addr;
  logic [3:0] phase;
  logic [PC_W-1:0] pc_out;
  logic [DW-1:0] working_register;
  logic [DW-1:0] tbl_latch;
  logic exec_valid;
  logic bad_seen = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;

  always #4 clk = ~clk;

  ifp_core dut (.CLK(clk), .RST_N(rst_n), .PM_RDATA(pm_rdata), .PM_ADDR(pm_addr), .PHASE(phase),
                .PC_OUT(pc_out), .WORKING_REGISTER_OUT(working_register), .TBL_LATCH_OUT(tbl_latch),
                .EXEC_VALID(exec_valid));
  ifp_rom_model rom (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

  // Wrong-path words load 99, 77 or 66; seeing one means a flush or a skip failed
  always @(negedge clk) begin
    if (rst_n === 1'b1 && (working_register === 8'h99 || working_register === 8'h77 ||
                           working_register === 8'h66 || pc_out[0] !== 1'b0)) begin
      bad_seen <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rst_n = 1'b0;
    tick(12);
    check(32'(phase), 32'h1);
    check(32'(pc_out), 32'h0);
    check(32'(pm_addr), 32'h0);
    check(32'(exec_valid), 32'h0);
    check(32'(working_register), 32'h0);
    check(32'(tbl_latch), 32'h0);
    rst_n = 1'b1;
  endtask : t_reset

  task automatic t_first_cycles;
    for (int i = 1; i <= 8; i++) begin
      tick(1);
      check(32'(phase), 32'h1 << (i % 4));
      if (i == 2) check(32'(pc_out), 32'h2);
      if (i == 4) check(32'(exec_valid), 32'h0);
      if (i == 5) check(32'(pc_out), 32'h4);
      if (i == 5) check(32'(exec_valid), 32'h1);
      if (i == 8) check(32'(working_register), 32'h55);
    end
  endtask : t_first_cycles

  // Jump, skip over a literal load, a lone second word, table read, computed jump, then a call returning W=42
  task automatic t_program;
    int n;
    n = 0;
    while (working_register !== 8'h42 && n < 300) begin
      tick(1);
      n++;
    end
    if (n >= 300) begin
      n_mismatch++;
      complete_run();
    end
    check(32'(tbl_latch), 32'hef);
    check(32'(pc_out), 32'h22);
    check(32'(bad_seen), 32'h0);
  endtask : t_program

  // Two-word move loads W from the table latch, then a branch of minus one word holds the counter in 26..2a
  task automatic t_branch_loop;
    for (int i = 0; i < 48; i++) begin
      tick(1);
      if (i >= 8) check(32'(pc_out >= 21'h000026 && pc_out <= 21'h00002a), 32'h1);
    end
    check(32'(working_register), 32'hef);
  endtask : t_branch_loop

  initial begin
    t_reset();
    t_first_cycles();
    t_program();
    t_branch_loop();
    t_reset();
    complete_run();
  end
endmodule : testbench
